// ### tb.sv
// Self-checking bench for the channel block.
`timescale 1ns/1ps
`include "uhr_consts.vh"
module tb;
  // ==========================================================
  // Stimulus and wiring
  reg        clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1;
  reg        wr_n = 1'b1, os_tick = 1'b0, sin = 1'b1, rx_valid = 1'b0;
  reg        stall = 1'b0, fe = 1'b0, dl = 1'b0, ce = 1'b1;
  reg  [3:0] rerr = 4'h0;
  reg  [4:0] trig = 5'h02;
  reg  [2:0] addr = 3'h0;
  reg  [7:0] wdata = 8'h00, rx_data = 8'h00, r;
  reg  [3:0] md = 4'h0;
  reg [15:0] rows [0:3];
  integer    fails = 0, n_tests = 0, cyc = 0, sv_n = 0, i;
  wire [7:0] rdata, tx_data, got;
  wire       tx_valid, tx_ready, idle, start_valid, rx_ready, irq;
  always #10 clk = ~clk;
  uhr_channel uhr_channel_inst (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata),
    .rdata(rdata), .dlab(dl), .fifo_en(fe), .rx_trigger(trig),
    .os_tick(os_tick), .modem_delta(md), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_shift_idle(idle),
    .sin(sin), .start_valid(start_valid), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_err(rerr),
    .channel_a_irq(irq));
  uhr_tx_sink uhr_tx_sink_inst (.clk(clk), .rst_n(rst_n), .stall(stall),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_shift_idle(idle), .got(got));
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (start_valid === 1'b1) sv_n = sv_n + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ==========================================================
  // Tasks
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Select is low for every access; the latch bit dl is left as the caller set it.
  task acc(input w, input [2:0] a, input [7:0] d);
    begin
      @(posedge clk) #1 cs_n = 1'b0;
      addr = a;
      wdata = d;
      if (w) wr_n = 1'b0;
      else rd_n = 1'b0;
      @(posedge clk) #1 r = rdata;
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      @(posedge clk) #1;
    end
  endtask
  task ticks(input integer n);
    repeat (n) begin
      @(posedge clk) #1 os_tick = 1'b1;
      @(posedge clk) #1 os_tick = 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ==========================================================
  // Sequence
  initial begin
    rows[0] = 16'hFF0F;
    rows[1] = 16'hA505;
    rows[2] = 16'h5A0A;
    rows[3] = 16'hF000;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    acc(0, `UHR_ADDR_IRQ_EN, 8'h00);
    chk(r, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, `UHR_ADDR_IRQ_EN, rows[i][15:8]);
      acc(0, `UHR_ADDR_IRQ_EN, 8'h00);
      chk(r, rows[i][7:0]);
    end
    $display("enable register test done");
    stall = 1'b1;
    acc(1, `UHR_ADDR_HOLD, 8'h3C);
    acc(1, `UHR_ADDR_HOLD, 8'h99);
    chk(tx_data, 8'h3C);
    acc(1, `UHR_ADDR_IRQ_EN, 8'h02);
    chk({7'h00, irq}, 8'h00);
    stall = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(got, 8'h3C);
    chk({7'h00, irq}, 8'h01);
    acc(0, `UHR_ADDR_LINE_STAT, 8'h00);
    chk({7'h00, r[5]}, 8'h01);
    $display("transmit test done");
    acc(1, `UHR_ADDR_IRQ_EN, 8'h01);
    rx_valid = 1'b1;
    rx_data = 8'h5A;
    @(posedge clk) #1 rx_valid = 1'b0;
    chk({7'h00, irq}, 8'h01);
    acc(0, `UHR_ADDR_HOLD, 8'h00);
    chk(r, 8'h5A);
    chk({7'h00, irq}, 8'h00);
    $display("receive test done");
    sin = 1'b0;
    ticks(8);
    repeat (3) @(posedge clk);
    #1 sin = 1'b1;
    chk(sv_n[7:0], 8'h01);
    repeat (2) @(posedge clk);
    #1 sin = 1'b0;
    ticks(3);
    sin = 1'b1;
    ticks(6);
    repeat (3) @(posedge clk);
    #1 chk(sv_n[7:0], 8'h01);
    $display("start bit test done");
    acc(1, `UHR_ADDR_IRQ_EN, 8'h08);
    md = 4'h1;
    #1 chk({7'h00, irq}, 8'h01);
    acc(1, `UHR_ADDR_IRQ_EN, 8'h00);
    chk({7'h00, irq}, 8'h00);
    md = 4'h0;
    $display("modem test done");
    acc(1, `UHR_ADDR_IRQ_EN, 8'h07);
    rx_valid = 1'b1;
    rx_data = 8'hC3;
    rerr = 4'h1;
    @(posedge clk) #1 rx_valid = 1'b0;
    rerr = 4'h0;
    acc(0, `UHR_ADDR_IDENT, 8'h00);
    chk(r, {4'h0, `UHR_ID_LS});
    acc(0, `UHR_ADDR_LINE_STAT, 8'h00);
    chk(r, 8'h63);
    acc(0, `UHR_ADDR_IDENT, 8'h00);
    chk(r, {4'h0, `UHR_ID_RX});
    acc(0, `UHR_ADDR_HOLD, 8'h00);
    chk(r, 8'hC3);
    acc(0, `UHR_ADDR_IDENT, 8'h00);
    chk(r, {4'h0, `UHR_ID_TX});
    acc(0, `UHR_ADDR_IDENT, 8'h00);
    chk(r, {4'h0, `UHR_ID_NONE});
    chk({7'h00, irq}, 8'h00);
    $display("status and ident test done");
    fe = 1'b1;
    acc(1, `UHR_ADDR_IRQ_EN, 8'h01);
    rx_valid = 1'b1;
    rx_data = 8'h11;
    @(posedge clk) #1 chk({7'h00, irq}, 8'h00);
    rx_data = 8'h22;
    @(posedge clk) #1 rx_valid = 1'b0;
    chk({7'h00, irq}, 8'h01);
    acc(0, `UHR_ADDR_HOLD, 8'h00);
    chk(r, 8'h11);
    chk({7'h00, irq}, 8'h00);
    acc(0, `UHR_ADDR_HOLD, 8'h00);
    chk(r, 8'h22);
    stall = 1'b1;
    acc(1, `UHR_ADDR_IRQ_EN, 8'h02);
    acc(1, `UHR_ADDR_HOLD, 8'h44);
    acc(1, `UHR_ADDR_HOLD, 8'h55);
    chk({7'h00, irq}, 8'h00);
    stall = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(got, 8'h55);
    chk({7'h00, irq}, 8'h01);
    fe = 1'b0;
    dl = 1'b1;
    acc(1, `UHR_ADDR_IRQ_EN, 8'h0F);
    dl = 1'b0;
    acc(0, `UHR_ADDR_IRQ_EN, 8'h00);
    chk(r, 8'h02);
    ce = 1'b0;
    acc(1, `UHR_ADDR_IRQ_EN, 8'h0F);
    ce = 1'b1;
    acc(0, `UHR_ADDR_IRQ_EN, 8'h00);
    chk(r, 8'h02);
    $display("fifo and access test done");
    stall = 1'b1;
    acc(1, `UHR_ADDR_HOLD, 8'h66);
    acc(1, `UHR_ADDR_IRQ_EN, 8'h0F);
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    stall = 1'b0;
    chk({7'h00, tx_valid}, 8'h00);
    acc(0, `UHR_ADDR_IRQ_EN, 8'h00);
    chk(r, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("reset test done");
    tally_and_finish;
  end
endmodule

// ### uhr_channel.v
// One UART channel: holding registers, start validation, INTERRUPT_SOURCE_ENABLES.
// Behaviour
// - 8-bit holding register feeds shift register
// - host write loads holding register when empty
// - holding-empty flag set when byte moves
// - host read returns and removes oldest byte
// - falling edge starts 16x counter
// - mid-start sample, reject false start
// - receive status reported in line status
// - enables mask four sources to irq
// - upper enable bits unused, read zero
// - modem change raises enabled interrupt
// - receive errors raise enabled line interrupt
// - no FIFO: tx interrupt follows holding-empty
// - FIFO: tx interrupt when FIFO, holding and shift register empty
// - no FIFO: rx interrupt while data held
// - FIFO: rx interrupt at trigger level
// - enables reset to disabled
// - rx priority two, tx priority three
`timescale 1ns/1ps
`include "uhr_consts.vh"
module uhr_channel (
  // Clock, reset and enable
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  // Host bus
  input  wire       cs_n,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  // Configuration from the surrounding channel
  input  wire       dlab,
  input  wire       fifo_en,
  input  wire [4:0] rx_trigger,
  input  wire       os_tick,
  input  wire [3:0] modem_delta,
  // Transmit shifter handshake
  output wire       tx_valid,
  input  wire       tx_ready,
  output wire [7:0] tx_data,
  input  wire       tx_shift_idle,
  // Serial input
  input  wire       sin,
  output wire       start_valid,
  // Receive shifter handshake and status
  input  wire       rx_valid,
  output wire       rx_ready,
  input  wire [7:0] rx_data,
  input  wire [3:0] rx_err,
  // Interrupt
  output wire       channel_a_irq
);
  // ==========================================================
  // Bus decode; the host keeps DLAB low when reaching these registers.
  wire acc = !cs_n && !dlab;
  wire wr_hold = acc && !wr_n && addr == `UHR_ADDR_HOLD;
  wire wr_en   = acc && !wr_n && addr == `UHR_ADDR_IRQ_EN;
  wire rd_any  = acc && !rd_n;
  wire rd_hold = rd_any && addr == `UHR_ADDR_HOLD;
  wire rd_stat = rd_any && addr == `UHR_ADDR_LINE_STAT;
  wire rd_id   = rd_any && addr == `UHR_ADDR_IDENT;
  reg  rd_any_q;
  reg  rd_hold_q;
  reg  rd_stat_q;
  reg  rd_id_q;
  wire rd_hold_p = rd_hold && !rd_hold_q;
  wire rd_stat_p = rd_stat && !rd_stat_q;
  wire rd_id_p   = rd_id && !rd_id_q;
  reg  wr_hold_q;
  wire wr_hold_p = wr_hold && !wr_hold_q;
  // ==========================================================
  // Interrupt enables, upper nibble not stored.
  // Only four flops are kept; the upper bits always read back as
  // zero, so software that writes ones there sees them dropped.
  reg  [3:0] en_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= `UHR_EN_RESET;
    end else if (clk_en && wr_en) begin
      en_q <= wdata[3:0];
    end
  end
  // ==========================================================
  // Two-entry transmit buffer: entry 0 is the holding register.
  // Writes while both entries are full are dropped, so a stalled
  // shifter never loses a byte already accepted.
  reg  [7:0] tbuf_q [0:`UHR_BUF_DEPTH-1];
  reg  [1:0] tcnt_q;
  wire tpush = wr_hold_p && (tcnt_q != 2'h2) &&
               (fifo_en || tcnt_q == 2'h0);
  wire tpop  = (tcnt_q != 2'h0) && tx_ready;
  assign tx_valid = tcnt_q != 2'h0;
  assign tx_data  = tbuf_q[0];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q    <= 2'h0;
      tbuf_q[0] <= 8'h00;
      tbuf_q[1] <= 8'h00;
    end else if (clk_en) begin
      if (tpop) begin
        tbuf_q[0] <= tbuf_q[1];
      end
      if (tpush) begin
        if (tcnt_q == 2'h0 || (tcnt_q == 2'h1 && tpop)) begin
          tbuf_q[0] <= wdata;
        end else begin
          tbuf_q[1] <= wdata;
        end
      end
      tcnt_q <= tcnt_q + {1'b0, tpush} - {1'b0, tpop};
    end
  end
  // Empty once the byte has moved into the shifter.
  wire thre = tcnt_q == 2'h0;
  wire temt = thre && tx_shift_idle;
  // ==========================================================
  // Start-bit qualifier on the 16x tick.
  localparam S_IDLE = 2'b01;
  localparam S_CHK  = 2'b10;
  reg  [1:0] st_q;
  reg  [3:0] os_q;
  reg        sin_q;
  reg        ok_q;
  assign start_valid = ok_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= S_IDLE;
      os_q  <= 4'h0;
      sin_q <= 1'b1;
      ok_q  <= 1'b0;
    end else if (clk_en) begin
      sin_q <= sin;
      ok_q  <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (sin_q && !sin) begin
            st_q <= S_CHK;
            os_q <= 4'h0;
          end
        end
        S_CHK: begin
          if (os_tick) begin
            os_q <= os_q + 4'h1;
            if (os_q == `UHR_MID_START) begin
              ok_q <= !sin;
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Receive buffer: two flop entries in front of the host.
  reg  [7:0] rbuf_q [0:`UHR_BUF_DEPTH-1];
  reg  [1:0] rcnt_q;
  assign rx_ready = rcnt_q != 2'h2;
  wire rpush = rx_valid && rx_ready;
  wire rpop  = rd_hold_p && rcnt_q != 2'h0;
  reg  [3:0] err_q;
  reg        ovr_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q    <= 2'h0;
      rbuf_q[0] <= 8'h00;
      rbuf_q[1] <= 8'h00;
      err_q     <= 4'h0;
      ovr_q     <= 1'b0;
    end else if (clk_en) begin
      if (rpop) begin
        rbuf_q[0] <= rbuf_q[1];
      end
      if (rpush) begin
        if (rcnt_q == 2'h0 || (rcnt_q == 2'h1 && rpop)) begin
          rbuf_q[0] <= rx_data;
        end else begin
          rbuf_q[1] <= rx_data;
        end
      end
      rcnt_q <= rcnt_q + {1'b0, rpush} - {1'b0, rpop};
      // A new error wins over the clear by a status read.
      err_q <= (rd_stat_p ? 4'h0 : err_q) |
               (rpush ? rx_err : 4'h0);
      ovr_q <= (rd_stat_p ? 1'b0 : ovr_q) | (rx_valid && !rx_ready);
    end
  end
  wire [3:0] err_all = err_q | {3'b000, ovr_q};
  wire [7:0] line_stat = {1'b0, temt, thre, err_all, rcnt_q != 2'h0};
  // ==========================================================
  // Interrupt sources, before enable masking.
  wire rx_src = fifo_en ? ({3'b000, rcnt_q} >= rx_trigger)
                        : (rcnt_q != 2'h0);
  wire tx_src = fifo_en ? (tcnt_q == 2'h0 && temt)
                        : thre;
  wire ls_src = |err_all;
  wire ms_src = |modem_delta;
  // ==========================================================
  // Strobe history, so that a long strobe acts only once.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_any_q  <= 1'b0;
      rd_hold_q <= 1'b0;
      rd_stat_q <= 1'b0;
      rd_id_q   <= 1'b0;
      wr_hold_q <= 1'b0;
    end else if (clk_en) begin
      rd_any_q  <= rd_any;
      rd_hold_q <= rd_hold;
      rd_stat_q <= rd_stat;
      rd_id_q   <= rd_id;
      wr_hold_q <= wr_hold;
    end
  end
  // ==========================================================
  // Pending sources and priority.
  reg  [3:0] id_code;
  reg        tx_ack_q;
  wire [3:0] pend = {ms_src, ls_src, tx_src && !tx_ack_q, rx_src} &
                    en_q;
  always @* begin
    if (pend[`UHR_IE_LS]) begin
      id_code = `UHR_ID_LS;
    end else if (pend[`UHR_IE_RX]) begin
      id_code = `UHR_ID_RX;
    end else if (pend[`UHR_IE_TX]) begin
      id_code = `UHR_ID_TX;
    end else if (pend[`UHR_IE_MS]) begin
      id_code = `UHR_ID_MS;
    end else begin
      id_code = `UHR_ID_NONE;
    end
  end
  // The empty interrupt is also cleared by an ident read that shows
  // it. A refill drops the source, which rearms the interrupt, so the
  // next time the path drains the host hears of it again.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ack_q <= 1'b0;
    end else if (clk_en) begin
      if (!tx_src) begin
        tx_ack_q <= 1'b0;
      end else if (rd_id_p && id_code == `UHR_ID_TX) begin
        tx_ack_q <= 1'b1;
      end
    end
  end
  assign channel_a_irq = |pend;
  // ==========================================================
  // Read data selection.
  reg  [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (addr)
      `UHR_ADDR_HOLD: begin
        rd_mux = rbuf_q[0];
      end
      `UHR_ADDR_IRQ_EN: begin
        rd_mux = {4'h0, en_q};
      end
      `UHR_ADDR_IDENT: begin
        rd_mux = {fifo_en, fifo_en, 2'b00, id_code};
      end
      `UHR_ADDR_LINE_STAT: begin
        rd_mux = line_stat;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end
  // Read data is taken on the first cycle of a strobe and then held.
  // A status or ident read changes what it reads, so a live mux would
  // let the host see the value move under a long strobe.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      if (rd_any && !rd_any_q) begin
        rdata <= rd_mux;
      end else if (!rd_any) begin
        rdata <= 8'h00;
      end
    end
  end
endmodule

// ### uhr_chk_asserts.sv
// Port-level assertions for one channel.
`timescale 1ns/1ps
// ==========================================================
// Checker
module uhr_chk (
  // Clock and reset
  input wire       clk,
  input wire       rst_n,
  input wire       clk_en,
  // Host bus
  input wire       cs_n,
  input wire       rd_n,
  input wire       wr_n,
  input wire       dlab,
  input wire       fifo_en,
  input wire [2:0] addr,
  input wire [7:0] rdata,
  // Streams
  input wire       tx_valid,
  input wire       tx_ready,
  input wire [7:0] tx_data,
  input wire       rx_valid,
  input wire       rx_ready,
  input wire       start_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_on;
    !cs_n && !rd_n && !dlab && clk_en;
  endsequence
  rd_stand_a:
    assert property (rd_on [*2] |=> $stable(rdata))
    else $error("read data moved during a read");
  tx_push_a:
    assert property ($rose(tx_valid) |->
      $past(!cs_n && !wr_n && !dlab && clk_en && addr == 3'h0))
    else $error("transmit byte appeared without a write");
  tx_keep_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("held transmit byte lost while stalled");
  tx_drain_a:
    assert property (tx_valid && tx_ready && clk_en && !fifo_en && wr_n
      |=> !tx_valid)
    else $error("holding register not emptied by the shifter");
  tx_fall_a:
    assert property ($fell(tx_valid) |-> $past(tx_ready))
    else $error("transmit byte vanished without a take");
  rx_fill_a:
    assert property ($fell(rx_ready) |-> $past(rx_valid))
    else $error("receive buffer filled without a byte");
  rx_pop_a:
    assert property ($rose(rx_ready) |->
      $past(!cs_n && !rd_n && !dlab && addr == 3'h0))
    else $error("receive byte removed without a read");
  start_one_a:
    assert property (start_valid |=> !start_valid)
    else $error("start pulse longer than one cycle");
endmodule
bind uhr_channel uhr_chk uhr_chk_inst (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n), .rd_n(rd_n),
  .wr_n(wr_n), .dlab(dlab), .fifo_en(fifo_en), .addr(addr), .rdata(rdata),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .start_valid(start_valid)
);

// ### uhr_consts.vh
// Constants for the UART holding path and interrupt enable block.
`ifndef UHR_CONSTS_VH
`define UHR_CONSTS_VH
// ==========================================================
// Register addresses (A2..A0)
`define UHR_ADDR_HOLD      3'h0
`define UHR_ADDR_IRQ_EN    3'h1
`define UHR_ADDR_IDENT     3'h2
`define UHR_ADDR_LINE_STAT 3'h5
// ==========================================================
// Enable bit positions
`define UHR_IE_RX          0
`define UHR_IE_TX          1
`define UHR_IE_LS          2
`define UHR_IE_MS          3
`define UHR_EN_RESET       4'h0
// ==========================================================
// Line status bit positions
`define UHR_LS_DR          0
`define UHR_LS_OE          1
`define UHR_LS_FE          3
`define UHR_LS_BI          4
`define UHR_LS_THRE        5
`define UHR_LS_TEMT        6
// ==========================================================
// Interrupt identification codes (priority level in bits 3..1)
`define UHR_ID_NONE        4'h1
`define UHR_ID_LS          4'h6
`define UHR_ID_RX          4'h4
`define UHR_ID_TX          4'h2
`define UHR_ID_MS          4'h0
// ==========================================================
// Timing: oversampling ticks to mid start bit (7.5 rounds up to 8)
`define UHR_OS_PER_BIT     4'hF
`define UHR_MID_START      4'h7
`define UHR_FIFO_DEPTH     5'h10
`define UHR_BUF_DEPTH      2
`endif

// ### uhr_tx_sink.sv
// Transmit shift register stand-in that takes bytes from the holding path.
`timescale 1ns/1ps
// ==========================================================
// Shift register model
module uhr_tx_sink (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Stall request from the bench
  input  wire       stall,
  // Holding path handshake
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output wire       tx_ready,
  output wire       tx_shift_idle,
  // Last byte taken
  output reg  [7:0] got
);
  // Idle only while nothing waits, so a stall also shows as busy.
  assign tx_ready      = !stall;
  assign tx_shift_idle = !tx_valid;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      got <= tx_data;
    end
  end
endmodule
